// [hdl/acdei_pkg.sv]
// Purpose: Shared constants and types of the command decode block.
// Assumes: 32-bit APB data, one word per register.
// Notes:   Printed offsets are word indices; byte address is four times it.
package acdei_pkg;

	// Word indices of the documented registers and their byte addresses.
	localparam logic [7:0]  IDX_EOL_INFO = 8'h10;
	localparam logic [7:0]  IDX_CMD_B0   = 8'h14;
	localparam logic [7:0]  IDX_CMD_B1   = 8'h15;
	localparam logic [11:0] ADDR_EOL_INFO = {2'b00, IDX_EOL_INFO, 2'b00};
	localparam logic [11:0] ADDR_CMD_B0   = {2'b00, IDX_CMD_B0, 2'b00};
	localparam logic [11:0] ADDR_CMD_B1   = {2'b00, IDX_CMD_B1, 2'b00};

	// Byte addresses of the control, status and mask registers.
	localparam logic [11:0] ADDR_CTRL   = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_MASK   = 12'h008;

	// Control register bit positions.
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_SRESET_BIT = 1;
	localparam int CTRL_SPACC_BIT  = 2;

	// End-of-list information bit positions.
	localparam int EOL_LIST_BIT = 7;
	localparam int EOL_BUF_BIT  = 6;

	// Command byte zero fields (type, reserved pair, flag select).
	localparam int B0_TYPE_POS = 6;
	localparam int B0_RSV_POS  = 4;
	localparam int B0_FSEL_POS = 0;

	// Command byte one fields (references and channel).
	localparam int B1_HREF_BIT = 7;
	localparam int B1_LREF_BIT = 6;
	localparam int B1_CH_POS   = 0;

	// Status and mask layout: end-of-list, conversion flags, error.
	localparam int ST_EOL_BIT  = 0;
	localparam int ST_CONV_LSB = 1;
	localparam int ST_ERR_BIT  = 16;
	localparam int ST_WIDTH    = 17;

	// Channel code landmarks.
	localparam logic [5:0] CH_LOW_REF  = 6'h00;
	localparam logic [5:0] CH_HIGH_REF = 6'h01;
	localparam logic [5:0] CH_MID_REF  = 6'h02;
	localparam logic [5:0] CH_INT_BASE = 6'h08;
	localparam logic [5:0] CH_EXT_BASE = 6'h10;

	// Reset values.
	localparam logic [2:0]  CTRL_RESET = 3'h0;
	localparam logic [7:0]  CMD_RESET  = 8'h00;
	localparam logic [16:0] MASK_RESET = 17'h00000;

	// Command type after decoding.
	typedef enum logic [1:0] {
		ACDEI_NORMAL,
		ACDEI_END_SEQ,
		ACDEI_WRAP_GO,
		ACDEI_WRAP_WAIT
	} acdei_type_t;

	// Kind of conversion input selected by the channel code.
	typedef enum logic [2:0] {
		ACDEI_SRC_LOW,
		ACDEI_SRC_HIGH,
		ACDEI_SRC_MID,
		ACDEI_SRC_INTERNAL,
		ACDEI_SRC_EXTERNAL,
		ACDEI_SRC_NONE
	} acdei_src_t;

	// Fully decoded command.
	typedef struct packed {
		acdei_type_t cmd_type;
		logic [15:1] flag_onehot;
		logic        high_ref_sel;
		logic        low_ref_sel;
		acdei_src_t  src_kind;
		logic [5:0]  src_index;
		logic        reserved;
	} acdei_decode_t;

	// Completion event reported by the list engine.
	typedef struct packed {
		logic done;
		logic list_active;
		logic buffer_active;
	} acdei_done_t;

endpackage

// [hdl/acdei_cmd_decode.sv]
// Purpose: Combinational decode of the two command bytes.
// Assumes: NUM_INPUTS external inputs are implemented.
// Notes:   Any reserved setting raises the reserved output.
`timescale 1ns/10ps
module acdei_cmd_decode #(
	parameter int NUM_INPUTS = 16
) (
	input  wire logic [7:0]             cmd_b0,
	input  wire logic [7:0]             cmd_b1,
	output acdei_pkg::acdei_decode_t    dec
);

	logic [1:0] type_code; // Command type field.
	logic [3:0] fsel;      // Binary flag select field.
	logic [5:0] ch;        // Channel select field.

	// Splits the bytes and decodes every field into the output struct.
	always_comb begin
		type_code = cmd_b0[acdei_pkg::B0_TYPE_POS +: 2];
		fsel = cmd_b0[acdei_pkg::B0_FSEL_POS +: 4];
		ch = cmd_b1[acdei_pkg::B1_CH_POS +: 6];
		dec = '0;
		// Type code to command kind.
		unique case (type_code)
			2'b00: dec.cmd_type = acdei_pkg::ACDEI_NORMAL;
			2'b01: dec.cmd_type = acdei_pkg::ACDEI_END_SEQ;
			2'b10: dec.cmd_type = acdei_pkg::ACDEI_WRAP_GO;
			2'b11: dec.cmd_type = acdei_pkg::ACDEI_WRAP_WAIT;
		endcase
		// One-hot flag; code zero leaves all flags clear.
		for (int i = 1; i < 16; i++) begin
			dec.flag_onehot[i] = (fsel == 4'(i));
		end
		dec.high_ref_sel = cmd_b1[acdei_pkg::B1_HREF_BIT];
		dec.low_ref_sel = cmd_b1[acdei_pkg::B1_LREF_BIT];
		// Unused bits of byte zero count as a reserved setting.
		dec.reserved = |cmd_b0[acdei_pkg::B0_RSV_POS +: 2];
		dec.src_kind = acdei_pkg::ACDEI_SRC_NONE;
		dec.src_index = 6'h00;
		if (ch == acdei_pkg::CH_LOW_REF) begin
			dec.src_kind = acdei_pkg::ACDEI_SRC_LOW;
		end else if (ch == acdei_pkg::CH_HIGH_REF) begin
			dec.src_kind = acdei_pkg::ACDEI_SRC_HIGH;
		end else if (ch == acdei_pkg::CH_MID_REF) begin
			dec.src_kind = acdei_pkg::ACDEI_SRC_MID;
		end else if (ch < acdei_pkg::CH_INT_BASE) begin
			// Codes three to seven are reserved.
			dec.reserved = 1'b1;
		end else if (ch < acdei_pkg::CH_EXT_BASE) begin
			dec.src_kind = acdei_pkg::ACDEI_SRC_INTERNAL;
			dec.src_index = {3'b000, ch[2:0]};
		end else if (!ch[5] && ({2'b00, ch[3:0]} < 6'(NUM_INPUTS))) begin
			// External input index counts up from zero.
			dec.src_kind = acdei_pkg::ACDEI_SRC_EXTERNAL;
			dec.src_index = {2'b00, ch[3:0]};
		end else begin
			// Top bit set, or an input that is not implemented.
			dec.reserved = 1'b1;
		end
	end

endmodule

// [hdl/acdei_top.sv]
// Purpose: Command decode and end-of-list information for a list ADC.
// Assumes: APB slave at 100 MHz; list engine gives one-cycle pulses.
// Notes:   Registers answer two cycles after the setup cycle.
`timescale 1ns/10ps
// Summary of operation
// - Info cleared by soft reset or disable.
// - Bit 7 records list active at end.
// - Bit 6 records result buffer at end.
// - Flag and info update together.
// - Info readable always, writes ignored.
// - Command writes only with special access set.
// - Type 00 normal, 01 sequence end.
// - Type 10 wraps and continues converting.
// - Type 11 wraps, waits per trigger mode.
// - Flag select picks one flag, zero none.
// - Reserved setting sets error, stops converter.
// - Bit 23 picks high reference input.
// - Bit 22 picks low reference input.
// - Channel 0,1,2 references; 3-7 reserved.
// - Channels 8-15 pick internal sources.
// - Codes 01xxxx external; top bit reserved.
module acdei_top #(
	parameter int NUM_INPUTS = 16
) (
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [11:0]             paddr,
	input  wire logic [31:0]             pwdata,
	input  wire logic [3:0]              pstrb,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	input  wire logic                    cmd_load,
	input  wire logic [15:0]             cmd_load_word,
	input  wire logic                    cmd_start,
	input  wire acdei_pkg::acdei_done_t  cmd_done,
	input  wire logic                    restart_mode,
	output logic                         converter_enable,
	output logic                         converter_halted,
	output logic                         high_reference_select,
	output logic                         low_reference_select,
	output acdei_pkg::acdei_src_t        input_channel_kind,
	output logic      [5:0]              input_channel_index,
	output logic                         seq_end_wait,
	output logic                         list_wrap_continue,
	output logic                         list_wrap_wait_restart,
	output logic                         list_wrap_wait_any,
	output logic                         irq
);

	// Only one to sixteen external inputs fit the four-bit index.
	if (NUM_INPUTS < 1 || NUM_INPUTS > 16) begin : g_check
		$error("NUM_INPUTS must lie between 1 and 16");
	end

	// All state of the block in one record.
	typedef struct packed {
		logic [2:0]  ctrl;
		logic [7:0]  cmd_b0;
		logic [7:0]  cmd_b1;
		logic        list_at_end;
		logic        buffer_at_end;
		logic [16:0] status;
		logic [16:0] mask;
		logic        halted;
		logic        href;
		logic        lref;
		acdei_pkg::acdei_src_t src_kind;
		logic [5:0]  src_index;
		logic        ev_seq_end;
		logic        ev_wrap_go;
		logic        ev_wrap_restart;
		logic        ev_wrap_any;
		logic        irq;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} acdei_state_t;

	acdei_state_t            st;        // Registered state.
	acdei_state_t            next_st;   // Next state.
	acdei_pkg::acdei_decode_t dec;      // Decode of the command bytes.
	logic                    enabled;   // Converter enable bit.
	logic                    clear_all; // Soft reset or disable.
	logic                    wr_en;     // Write completes this edge.
	logic                    access;    // Access phase is active.
	logic                    mapped;    // Address hits a register.
	logic [31:0]             rd_mux;    // Read value of the address.
	logic [16:0]             set_bits;  // Status bits set by events.
	logic [16:0]             clr_bits;  // Status bits cleared by software.
	logic                    run_ok;    // Events are accepted.

	// Decodes the command bytes currently held.
	acdei_cmd_decode #(
		.NUM_INPUTS (NUM_INPUTS)
	) u_decode (
		.cmd_b0 (st.cmd_b0),
		.cmd_b1 (st.cmd_b1),
		.dec    (dec)
	);

	// Read multiplexer and address decode.
	always_comb begin
		rd_mux = 32'h00000000;
		mapped = 1'b1;
		unique case (paddr)
			acdei_pkg::ADDR_CTRL: begin
				rd_mux = {29'h00000000, st.ctrl};
			end
			acdei_pkg::ADDR_STATUS: begin
				rd_mux = {15'h0000, st.status};
			end
			acdei_pkg::ADDR_MASK: begin
				rd_mux = {15'h0000, st.mask};
			end
			acdei_pkg::ADDR_EOL_INFO: begin
				// Readable at any time; low bits read as zero.
				rd_mux = {24'h000000, st.list_at_end, st.buffer_at_end,
					6'h00};
			end
			acdei_pkg::ADDR_CMD_B0: begin
				rd_mux = {24'h000000, st.cmd_b0};
			end
			acdei_pkg::ADDR_CMD_B1: begin
				rd_mux = {24'h000000, st.cmd_b1};
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// Next-state logic for bus, registers and command events.
	always_comb begin
		next_st = st;
		enabled = st.ctrl[acdei_pkg::CTRL_ENABLE_BIT];
		clear_all = st.ctrl[acdei_pkg::CTRL_SRESET_BIT] || !enabled;
		access = psel && penable;
		wr_en = access && st.pready && pwrite && mapped && pstrb[0];
		run_ok = !clear_all && !st.halted;
		set_bits = 17'h00000;
		clr_bits = 17'h00000;

		// Bus answer: ready one cycle into the access phase.
		next_st.pready = access && !st.pready;
		next_st.pslverr = access && !st.pready && !mapped;
		if (access && !st.pready) begin
			next_st.prdata = mapped ? rd_mux : 32'h00000000;
		end

		// Register writes take effect at the completing edge.
		if (wr_en) begin
			unique case (paddr)
				acdei_pkg::ADDR_CTRL: begin
					next_st.ctrl = pwdata[2:0];
				end
				acdei_pkg::ADDR_STATUS: begin
					clr_bits = pwdata[16:0];
				end
				acdei_pkg::ADDR_MASK: begin
					next_st.mask = pwdata[16:0];
				end
				acdei_pkg::ADDR_CMD_B0: begin
					// Ignored unless special access is set.
					if (st.ctrl[acdei_pkg::CTRL_SPACC_BIT]) begin
						next_st.cmd_b0 = pwdata[7:0];
					end
				end
				acdei_pkg::ADDR_CMD_B1: begin
					if (st.ctrl[acdei_pkg::CTRL_SPACC_BIT]) begin
						next_st.cmd_b1 = pwdata[7:0];
					end
				end
				default: begin
					// The info register ignores writes.
				end
			endcase
		end

		// The list engine may load a fresh command while running.
		if (cmd_load && run_ok) begin
			next_st.cmd_b0 = cmd_load_word[15:8];
			next_st.cmd_b1 = cmd_load_word[7:0];
		end

		// Event pulses last one cycle.
		next_st.ev_seq_end = 1'b0;
		next_st.ev_wrap_go = 1'b0;
		next_st.ev_wrap_restart = 1'b0;
		next_st.ev_wrap_any = 1'b0;

		// Starting a command with a reserved setting stops the converter.
		if (cmd_start && run_ok && dec.reserved) begin
			set_bits[acdei_pkg::ST_ERR_BIT] = 1'b1;
			next_st.halted = 1'b1;
		end else if (cmd_start && run_ok) begin
			// Reference and input selects for this conversion.
			next_st.href = dec.high_ref_sel;
			next_st.lref = dec.low_ref_sel;
			next_st.src_kind = dec.src_kind;
			next_st.src_index = dec.src_index;
		end

		// Completion with data stored: flags and list behaviour.
		if (cmd_done.done && run_ok) begin
			// Selected conversion flag.
			set_bits[acdei_pkg::ST_CONV_LSB +: 15] = dec.flag_onehot;
			unique case (dec.cmd_type)
				acdei_pkg::ACDEI_NORMAL: begin
					// Plain conversion; nothing more to signal.
				end
				acdei_pkg::ACDEI_END_SEQ: begin
					next_st.ev_seq_end = 1'b1;
				end
				acdei_pkg::ACDEI_WRAP_GO: begin
					next_st.ev_wrap_go = 1'b1;
				end
				acdei_pkg::ACDEI_WRAP_WAIT: begin
					// Wait behaviour follows the trigger mode.
					next_st.ev_wrap_restart = restart_mode;
					next_st.ev_wrap_any = !restart_mode;
				end
			endcase
			// Both end-of-list types update flag and info together.
			if (dec.cmd_type == acdei_pkg::ACDEI_WRAP_GO ||
				dec.cmd_type == acdei_pkg::ACDEI_WRAP_WAIT) begin
				set_bits[acdei_pkg::ST_EOL_BIT] = 1'b1;
				next_st.list_at_end = cmd_done.list_active;
				next_st.buffer_at_end = cmd_done.buffer_active;
			end
		end

		// Sticky status: a set in the same cycle beats the clear.
		next_st.status = (st.status & ~clr_bits) | set_bits;

		// Soft reset or disable wipes info, flags and the stop.
		if (clear_all) begin
			next_st.list_at_end = 1'b0;
			next_st.buffer_at_end = 1'b0;
			next_st.status = 17'h00000;
			next_st.halted = 1'b0;
		end

		// Level interrupt from unmasked status bits.
		next_st.irq = |(next_st.status & next_st.mask);
	end

	// Registers the whole state record.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st.ctrl <= acdei_pkg::CTRL_RESET;
			st.cmd_b0 <= acdei_pkg::CMD_RESET;
			st.cmd_b1 <= acdei_pkg::CMD_RESET;
			st.list_at_end <= 1'b0;
			st.buffer_at_end <= 1'b0;
			st.status <= 17'h00000;
			st.mask <= acdei_pkg::MASK_RESET;
			st.halted <= 1'b0;
			st.href <= 1'b0;
			st.lref <= 1'b0;
			st.src_kind <= acdei_pkg::ACDEI_SRC_NONE;
			st.src_index <= 6'h00;
			st.ev_seq_end <= 1'b0;
			st.ev_wrap_go <= 1'b0;
			st.ev_wrap_restart <= 1'b0;
			st.ev_wrap_any <= 1'b0;
			st.irq <= 1'b0;
			st.prdata <= 32'h00000000;
			st.pready <= 1'b0;
			st.pslverr <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flip-flops.
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign converter_enable = st.ctrl[acdei_pkg::CTRL_ENABLE_BIT];
	assign converter_halted = st.halted;
	assign high_reference_select = st.href;
	assign low_reference_select = st.lref;
	assign input_channel_kind = st.src_kind;
	assign input_channel_index = st.src_index;
	assign seq_end_wait = st.ev_seq_end;
	assign list_wrap_continue = st.ev_wrap_go;
	assign list_wrap_wait_restart = st.ev_wrap_restart;
	assign list_wrap_wait_any = st.ev_wrap_any;
	assign irq = st.irq;

endmodule

// [dv/acdei_top_sva.sv]
// Purpose: Protocol and decode checks on the top-level ports.
// Assumes: Single clock domain, asynchronous active-low reset.
// Notes:   Attached to every acdei_top instance by the bind below.
`timescale 1ns/10ps
module acdei_top_sva #(
	parameter int NUM_INPUTS = 16
) (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire acdei_pkg::acdei_done_t cmd_done,
	input wire logic                   restart_mode,
	input wire logic                   converter_enable,
	input wire acdei_pkg::acdei_src_t  input_channel_kind,
	input wire logic [5:0]             input_channel_index,
	input wire logic                   seq_end_wait,
	input wire logic                   list_wrap_continue,
	input wire logic                   list_wrap_wait_restart,
	input wire logic                   list_wrap_wait_any,
	input wire logic                   irq
);
	// All checks sample on the bus clock and pause during reset.
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_delay: assert property ((psel && !penable) |-> ##2 pready)
		else $error("pready not two cycles after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response without ready or with data");
	a_pulse_single: assert property ($onehot0({seq_end_wait,
		list_wrap_continue, list_wrap_wait_restart, list_wrap_wait_any}))
		else $error("more than one command type pulse");
	a_seq_end_cause: assert property (seq_end_wait |->
		$past(cmd_done.done))
		else $error("sequence end pulse without completion");
	a_wrap_go_cause: assert property (list_wrap_continue |->
		$past(cmd_done.done) && $past(converter_enable))
		else $error("wrap pulse without enabled completion");
	a_wait_restart: assert property (list_wrap_wait_restart |->
		$past(restart_mode) && $past(cmd_done.done))
		else $error("restart wait pulse outside restart mode");
	a_wait_trigger: assert property (list_wrap_wait_any |->
		!$past(restart_mode))
		else $error("trigger wait pulse in restart mode");
	a_off_quiet: assert property (!converter_enable |=> !irq)
		else $error("interrupt while converter disabled");
	a_int_range: assert property (input_channel_kind ==
		acdei_pkg::ACDEI_SRC_INTERNAL |-> input_channel_index < 6'h08)
		else $error("internal index out of range");
	a_ext_range: assert property (input_channel_kind ==
		acdei_pkg::ACDEI_SRC_EXTERNAL |-> input_channel_index < NUM_INPUTS)
		else $error("external index out of range");
	// Main scenarios reached.
	c_wrap: cover property (list_wrap_continue);
	c_wait_any: cover property (list_wrap_wait_any);
	c_bus_err: cover property (pslverr);
endmodule
bind acdei_top acdei_top_sva #(.NUM_INPUTS(NUM_INPUTS)) acdei_top_sva_i (
	.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
	.cmd_done, .restart_mode, .converter_enable, .input_channel_kind,
	.input_channel_index, .seq_end_wait, .list_wrap_continue,
	.list_wrap_wait_restart, .list_wrap_wait_any, .irq);

// [dv/adc_command_decode_eol_info_tb.sv]
// Purpose: Self-checking bench for the command decode block.
// Assumes: APB answers with one pready pulse per transfer.
// Notes:   Fewer external inputs than default to reach the limit case.
`timescale 1ns/10ps
module adc_command_decode_eol_info_tb;
	localparam int NUMI = 12;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, cmd_load = 1'b0, cmd_start = 1'b0;
	logic restart_mode = 1'b0, pready, pslverr, converter_enable;
	logic converter_halted, hrs, lrs, sew, lwc, lwr, lwa, irq;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [5:0]  idx;
	logic        err;
	acdei_pkg::acdei_done_t cmd_done = '0;
	acdei_pkg::acdei_src_t  kind;
	int bad_count = 0, n_tests = 0;
	// Free-running 100 MHz bus clock.
	always #5 pclk = ~pclk;
	acdei_top #(.NUM_INPUTS(NUMI)) acdei_top_i (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready,
		.pslverr, .cmd_load, .cmd_load_word(16'h0000), .cmd_start, .cmd_done,
		.restart_mode, .converter_enable, .converter_halted,
		.high_reference_select(hrs), .low_reference_select(lrs),
		.input_channel_kind(kind), .input_channel_index(idx),
		.seq_end_wait(sew), .list_wrap_continue(lwc),
		.list_wrap_wait_restart(lwr), .list_wrap_wait_any(lwa), .irq);
	// Prints counts and the verdict, then ends the run.
	task summarize;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Compares a seen value against the expected one.
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// One APB transfer; read data and error land in rd and err.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			bad_count++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	// Drives start and completion for one cycle, then settles past reply.
	task ev(input logic s, d, l, b, rm);
		@(posedge pclk);
		cmd_start <= s;
		cmd_done <= {d, l, b};
		restart_mode <= rm;
		@(posedge pclk);
		cmd_start <= 1'b0;
		cmd_done <= '0;
		#1;
	endtask
	// Expected {reserved, kind, index} for a channel code.
	function automatic logic [9:0] exp_ch(input logic [5:0] c);
		if (c < 6'h03)
			return {1'b0, c[2:0], 6'h00};
		if (c[5:3] == 3'b001)
			return {1'b0, acdei_pkg::ACDEI_SRC_INTERNAL, c - 6'h08};
		if (c[5:4] == 2'b01 && c[3:0] < NUMI)
			return {1'b0, acdei_pkg::ACDEI_SRC_EXTERNAL, c - 6'h10};
		return 10'h200;
	endfunction
	// Reset values, read-only info, guarded command writes, bad address.
	task t_regs;
		apb(1'b0, acdei_pkg::ADDR_EOL_INFO, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, acdei_pkg::ADDR_EOL_INFO, 32'hFF);
		apb(1'b0, acdei_pkg::ADDR_EOL_INFO, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, acdei_pkg::ADDR_CMD_B0, 32'hA5);
		apb(1'b0, acdei_pkg::ADDR_CMD_B0, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'hFFC, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		apb(1'b1, acdei_pkg::ADDR_CTRL, 32'h5);
		chk(converter_enable, 1'b1);
		apb(1'b1, acdei_pkg::ADDR_CMD_B1, 32'h5A);
		apb(1'b0, acdei_pkg::ADDR_CMD_B1, 32'h0);
		chk(rd, 32'h5A);
		apb(1'b1, acdei_pkg::ADDR_MASK, 32'h1FFFF);
		$display("register access done");
	endtask
	// Every command type in both wait modes, with flag selects 0, 3, 4, 5, 9, 10, 14 and 15.
	task t_types;
		logic [31:0] es, ei;
		logic [1:0]  t;
		logic [3:0]  f;
		ei = 32'h0;
		for (int k = 0; k < 8; k++) begin
			t = k[2:1];
			f = 4'(k * 5);
			// Commands change only between conversions.
			apb(1'b1, acdei_pkg::ADDR_CMD_B0, {24'h0, t, 2'b00, f});
			ev(1'b1, 1'b1, k[0], t[0], k[0]);
			es = 32'h0;
			if (f != 4'h0) es[f] = 1'b1;
			es[0] = t[1];
			chk({sew, lwc, lwr, lwa}, t == 2'd1 ? 4'h8 : t == 2'd2 ? 4'h4 :
				t == 2'd3 ? (k[0] ? 4'h2 : 4'h1) : 4'h0);
			chk(irq, es != 32'h0);
			if (t[1]) ei = {24'h0, k[0], t[0], 6'h00};
			apb(1'b0, acdei_pkg::ADDR_STATUS, 32'h0);
			chk(rd, es);
			apb(1'b0, acdei_pkg::ADDR_EOL_INFO, 32'h0);
			chk(rd, ei);
			apb(1'b1, acdei_pkg::ADDR_STATUS, 32'h1FFFF);
		end
		$display("command types done");
	endtask
	// All channel codes with references; reserved ones halt.
	task t_chan;
		logic [9:0] e;
		apb(1'b1, acdei_pkg::ADDR_CMD_B0, 32'h0);
		for (int c = 0; c < 64; c++) begin
			e = exp_ch(6'(c));
			apb(1'b1, acdei_pkg::ADDR_CMD_B1, {24'h0, c[0], c[1], 6'(c)});
			ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
			if (e[9]) begin
				chk(converter_halted, 1'b1);
				apb(1'b0, acdei_pkg::ADDR_STATUS, 32'h0);
				chk(rd[16], 1'b1);
				apb(1'b1, acdei_pkg::ADDR_CTRL, 32'h0);
				apb(1'b1, acdei_pkg::ADDR_CTRL, 32'h5);
				chk(converter_halted, 1'b0);
			end else begin
				chk({hrs, lrs, kind, idx},
					{c[0], c[1], e[8:0]});
			end
		end
		$display("channel codes done");
	endtask
	// Masking, soft reset, disable and a reserved bit in byte zero.
	task t_clear;
		apb(1'b1, acdei_pkg::ADDR_CMD_B0, 32'h81);
		ev(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
		apb(1'b1, acdei_pkg::ADDR_MASK, 32'h0);
		chk(irq, 1'b0);
		apb(1'b1, acdei_pkg::ADDR_MASK, 32'h1FFFF);
		chk(irq, 1'b1);
		apb(1'b1, acdei_pkg::ADDR_CTRL, 32'h7);
		ev(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
		chk({lwc, irq}, 2'b00);
		apb(1'b0, acdei_pkg::ADDR_EOL_INFO, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, acdei_pkg::ADDR_CTRL, 32'h5);
		ev(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
		apb(1'b0, acdei_pkg::ADDR_EOL_INFO, 32'h0);
		chk(rd, 32'h80);
		apb(1'b1, acdei_pkg::ADDR_CTRL, 32'h4);
		apb(1'b0, acdei_pkg::ADDR_EOL_INFO, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, acdei_pkg::ADDR_CTRL, 32'h5);
		apb(1'b1, acdei_pkg::ADDR_CMD_B0, 32'h10);
		ev(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		chk(converter_halted, 1'b1);
		$display("clearing done");
	endtask
	// Main sequence: reset for 12 cycles, then each scenario.
	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_types();
		t_chan();
		t_clear();
		summarize();
	end
endmodule
